// File: design/pll_cfg.svh
// register offsets, field positions, reset values and timing counts of the clock controller
`ifndef PLL_CFG_SVH
`define PLL_CFG_SVH

// ==========================================
// register offsets (byte addresses)
`define OFS_CTRL 12'h100
`define OFS_MULT 12'h110
`define OFS_PREDIV 12'h114
`define OFS_DIV_A 12'h118
`define OFS_DIV_B 12'h11C
`define OFS_DIV_C 12'h120
`define OFS_DIV_AUX 12'h124
`define OFS_CMD 12'h138
`define OFS_STAT 12'h13C
`define OFS_ALIGN 12'h140

// ==========================================
// field positions
`define CTRL_USE_BIT 0
`define CTRL_CORE_RST_BIT 1
`define CMD_GO_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_LOCK_BIT 1
`define STAT_RSTOK_BIT 2
`define STAT_ERR_BIT 3

// ==========================================
// reset values and limits
`define MULT_RST 5'h0D
`define MULT_MIN 5'h04
`define MULT_MAX 5'h19
`define PREDIV_RST 5'h01
`define DIV_A_RST 5'h01
`define DIV_B_RST 5'h02
`define DIV_C_RST 5'h03
`define DIV_AUX_RST 5'h01
`define ALIGN_RST 3'h0

// ==========================================
// timing
`define CLK_PERIOD_NS 10
`define CORE_RST_MIN_NS 125
`define LOCK_MIN_US 187.5

`endif

// File: design/pll_pkg.sv
// types shared by the clock controller and its divider unit
package pll_pkg;

   // divide or multiply factor, value used as is
   typedef logic [4:0] ratio_type;

   // one apb request as seen by the slave
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } apb_req_type;

   // divider change sequencer
   typedef enum logic {GO_IDLE, GO_WAIT} go_state_type;

endpackage : pll_pkg

// File: design/clk_div_unit.sv
// one programmable output divider producing a 50 percent clock level
`timescale 1ns/1ps
`default_nettype none

module clk_div_unit #(
   parameter pll_pkg::ratio_type RST_RATIO = 5'h01
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic load,
   input wire pll_pkg::ratio_type ratio_new,
   output logic clk_out,
   output logic at_end
);
   import pll_pkg::*;

   ratio_type cnt_r, cnt_nxt, ratio_r, ratio_nxt;
   logic out_r, out_nxt;

   // end of a whole period: this tick ends the high half
   assign at_end = tick && (cnt_r == ratio_r - 5'h01) && out_r;
   assign clk_out = out_r;

   // ==========================================
   // counter: level toggles every ratio ticks
   always_comb begin
      cnt_nxt = cnt_r;
      ratio_nxt = ratio_r;
      out_nxt = out_r;
      if (load) begin
         // restart low at count zero; aligned dividers load at a period boundary, others may cut a pulse short
         ratio_nxt = ratio_new;
         cnt_nxt = 5'h00;
         out_nxt = 1'b0;
      end else if (tick) begin
         if (cnt_r == ratio_r - 5'h01) begin
            cnt_nxt = 5'h00;
            out_nxt = ~out_r;
         end else begin
            cnt_nxt = cnt_r + 5'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 5'h00;
         ratio_r <= RST_RATIO;
         out_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ratio_r <= ratio_nxt;
         out_r <= out_nxt;
      end
   end

   // ==========================================
   // checks
   chk_toggle_at_count: assert property (@(posedge clk) disable iff (rst)
      $changed(out_r) && !$past(load) |-> $past(cnt_r) == $past(ratio_r) - 5'h01)
      else $error("divider toggled before its count ran out");
   chk_load_clears: assert property (@(posedge clk) disable iff (rst)
      load |=> cnt_r == 5'h00 && !out_r && ratio_r == $past(ratio_new))
      else $error("divider did not take the new ratio on load");

endmodule : clk_div_unit

`default_nettype wire

// File: design/pll_clock_ctrl.sv
// pll clock controller: apb registers, reference merge, lock timing, aligned divider change
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pll_cfg.svh"

module pll_clock_ctrl #(
   parameter int LOCK_CYCLES = int'($ceil(`LOCK_MIN_US * 1000.0 / `CLK_PERIOD_NS))
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic OSCILLATOR_INPUT,
   input wire logic EXTERNAL_CLOCK_PIN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic SYSTEM_CLOCK_A,
   output logic SYSTEM_CLOCK_B,
   output logic SYSTEM_CLOCK_C,
   output logic AUX_CLOCK,
   output logic PLL_USE_ENABLE,
   output logic PLL_CORE_RESET,
   output pll_pkg::ratio_type PLL_MULTIPLIER,
   output pll_pkg::ratio_type REFERENCE_PRE_DIVIDER
);
   import pll_pkg::*;

   localparam int CORE_RST_CYCLES = (`CORE_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
   localparam ratio_type div_rst_tab [4] = '{`DIV_A_RST, `DIV_B_RST, `DIV_C_RST, `DIV_AUX_RST};

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   // ==========================================
   // reference input: both pins synchronised, then merged
   logic osc_s1_r, osc_s2_r, ext_s1_r, ext_s2_r, ref_prev_r;
   logic ref_merged, ref_rise, src_tick;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ref_prev_r <= 1'b0;
      end else begin
         osc_s1_r <= OSCILLATOR_INPUT;
         osc_s2_r <= osc_s1_r;
         ext_s1_r <= EXTERNAL_CLOCK_PIN;
         ext_s2_r <= ext_s1_r;
         ref_prev_r <= ref_merged;
      end
   end

   // unused source must sit low, otherwise it corrupts the merged reference
   assign ref_merged = osc_s2_r | ext_s2_r;
   assign ref_rise = ref_merged && !ref_prev_r;

   // ==========================================
   // apb request and register file
   apb_req_type req;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic use_en_r, use_en_nxt, core_rst_r, core_rst_nxt;
   ratio_type mult_r, mult_nxt, prediv_r, prediv_nxt;
   ratio_type div_shadow_r [4];
   ratio_type div_shadow_nxt [4];
   logic [2:0] align_r, align_nxt;
   logic err_r, err_nxt;
   logic bad, ratio_ok, wr_done, go_req, core_set, lock_restart;
   logic [6:0] a7, b7;
   logic [31:0] rd_data;
   go_state_type go_state_r, go_state_nxt;
   logic [LOCK_W-1:0] lock_cnt_r, lock_cnt_nxt;
   logic [3:0] hold_cnt_r, hold_cnt_nxt;
   logic lock_done, reset_ok, fire;
   logic [3:0] at_end, clk_vec, align_mask;

   assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
   // a write takes effect only at the edge where pready is seen high
   assign wr_done = req.sel && req.enable && pready_r && req.write && !bad;

   // second clock must be 2, 3 or 4 times slower than the first
   assign a7 = {2'h0, div_shadow_r[0]};
   assign b7 = {2'h0, div_shadow_r[1]};
   assign ratio_ok = (b7 == 7'h02 * a7) || (b7 == 7'h03 * a7) || (b7 == 7'h04 * a7);

   // refusal of out of range writes and unmapped addresses
   always_comb begin
      bad = 1'b0;
      unique case (req.addr)
         `OFS_CTRL, `OFS_STAT, `OFS_ALIGN: bad = 1'b0;
         `OFS_MULT: bad = req.write && (req.wdata[4:0] < `MULT_MIN ||
                                        req.wdata[4:0] > `MULT_MAX);
         `OFS_PREDIV, `OFS_DIV_A, `OFS_DIV_B, `OFS_DIV_C, `OFS_DIV_AUX:
            bad = req.write && req.wdata[4:0] == 5'h00;
         `OFS_CMD: bad = req.write && req.wdata[`CMD_GO_BIT] && !ratio_ok;
         default: bad = 1'b1;
      endcase
   end

   // read mux, bits above each field read as zero
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (req.addr)
         `OFS_CTRL: begin
            rd_data[`CTRL_USE_BIT] = use_en_r;
            rd_data[`CTRL_CORE_RST_BIT] = core_rst_r;
         end
         `OFS_MULT: rd_data[4:0] = mult_r;
         `OFS_PREDIV: rd_data[4:0] = prediv_r;
         `OFS_DIV_A: rd_data[4:0] = div_shadow_r[0];
         `OFS_DIV_B: rd_data[4:0] = div_shadow_r[1];
         `OFS_DIV_C: rd_data[4:0] = div_shadow_r[2];
         `OFS_DIV_AUX: rd_data[4:0] = div_shadow_r[3];
         `OFS_STAT: begin
            rd_data[`STAT_BUSY_BIT] = (go_state_r == GO_WAIT);
            rd_data[`STAT_LOCK_BIT] = lock_done;
            rd_data[`STAT_RSTOK_BIT] = reset_ok;
            rd_data[`STAT_ERR_BIT] = err_r;
         end
         `OFS_ALIGN: rd_data[2:0] = align_r;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   assign go_req = wr_done && req.addr == `OFS_CMD && req.wdata[`CMD_GO_BIT];
   assign core_set = wr_done && req.addr == `OFS_CTRL && req.wdata[`CTRL_CORE_RST_BIT] &&
                     !core_rst_r;
   assign lock_restart = wr_done && (req.addr == `OFS_MULT || req.addr == `OFS_PREDIV);

   // register next values; one wait state before every answer
   always_comb begin
      pready_nxt = req.sel && req.enable && !pready_r;
      pslverr_nxt = pready_nxt && bad;
      prdata_nxt = (pready_nxt && !req.write) ? rd_data : 32'h0000_0000;
      use_en_nxt = use_en_r;
      core_rst_nxt = core_rst_r;
      mult_nxt = mult_r;
      prediv_nxt = prediv_r;
      div_shadow_nxt = div_shadow_r;
      align_nxt = align_r;
      err_nxt = err_r;
      if (wr_done) begin
         unique case (req.addr)
            `OFS_CTRL: begin
               use_en_nxt = req.wdata[`CTRL_USE_BIT];
               core_rst_nxt = req.wdata[`CTRL_CORE_RST_BIT];
            end
            `OFS_MULT: mult_nxt = req.wdata[4:0];
            `OFS_PREDIV: prediv_nxt = req.wdata[4:0];
            // shadows only: the running ratios change on go
            `OFS_DIV_A: div_shadow_nxt[0] = req.wdata[4:0];
            `OFS_DIV_B: div_shadow_nxt[1] = req.wdata[4:0];
            `OFS_DIV_C: div_shadow_nxt[2] = req.wdata[4:0];
            `OFS_DIV_AUX: div_shadow_nxt[3] = req.wdata[4:0];
            `OFS_ALIGN: align_nxt = req.wdata[2:0];
            default: err_nxt = err_r;
         endcase
      end
      // refused go raises the error flag, an accepted go clears it
      if (req.sel && req.enable && pready_r && req.write && req.addr == `OFS_CMD &&
          req.wdata[`CMD_GO_BIT]) begin
         err_nxt = bad;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         use_en_r <= 1'b0;
         core_rst_r <= 1'b1;
         mult_r <= `MULT_RST;
         prediv_r <= `PREDIV_RST;
         div_shadow_r <= div_rst_tab;
         align_r <= `ALIGN_RST;
         err_r <= 1'b0;
      end else begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
         use_en_r <= use_en_nxt;
         core_rst_r <= core_rst_nxt;
         mult_r <= mult_nxt;
         prediv_r <= prediv_nxt;
         div_shadow_r <= div_shadow_nxt;
         align_r <= align_nxt;
         err_r <= err_nxt;
      end
   end

   // ==========================================
   // core reset hold and lock timers, reported only; software owns the wait
   assign reset_ok = (hold_cnt_r == 4'(CORE_RST_CYCLES));
   assign lock_done = !core_rst_r && lock_cnt_r == '0;

   always_comb begin
      hold_cnt_nxt = hold_cnt_r;
      lock_cnt_nxt = lock_cnt_r;
      if (core_set) begin
         hold_cnt_nxt = 4'h0;
      end else if (core_rst_r && !reset_ok) begin
         hold_cnt_nxt = hold_cnt_r + 4'h1;
      end
      if (core_rst_r || lock_restart) begin
         lock_cnt_nxt = LOCK_W'(LOCK_CYCLES);
      end else if (lock_cnt_r != '0) begin
         lock_cnt_nxt = lock_cnt_r - 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         hold_cnt_r <= 4'h0;
         lock_cnt_r <= LOCK_W'(LOCK_CYCLES);
      end else begin
         hold_cnt_r <= hold_cnt_nxt;
         lock_cnt_r <= lock_cnt_nxt;
      end
   end

   // ==========================================
   // go sequencer: waits for every aligned divider to end a period together
   // waits as long as the common boundary takes; with no reference on the bypass path it waits forever unless align is zero, which fires at once
   assign align_mask = {1'b0, align_r};
   assign fire = (go_state_r == GO_WAIT) && &(at_end | ~align_mask);

   always_comb begin
      go_state_nxt = go_state_r;
      unique case (go_state_r)
         GO_IDLE: if (go_req) go_state_nxt = GO_WAIT;
         GO_WAIT: if (fire) go_state_nxt = GO_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         go_state_r <= GO_IDLE;
      end else begin
         go_state_r <= go_state_nxt;
      end
   end

   // ==========================================
   // four output dividers fed by the pll stand-in or by the reference
   // pll path: every system clock cycle stands for one pll output edge
   assign src_tick = use_en_r ? 1'b1 : ref_rise;

   for (genvar i = 0; i < 4; i++) begin : g_div
      clk_div_unit #(.RST_RATIO(div_rst_tab[i])) u_div (
         .clk(SYS_CLK),
         .rst(RST),
         .tick(src_tick),
         .load(fire),
         .ratio_new(div_shadow_r[i]),
         .clk_out(clk_vec[i]),
         .at_end(at_end[i])
      );
   end

   // all outputs come straight from flops
   assign SYSTEM_CLOCK_A = clk_vec[0];
   assign SYSTEM_CLOCK_B = clk_vec[1];
   assign SYSTEM_CLOCK_C = clk_vec[2];
   assign AUX_CLOCK = clk_vec[3];
   assign PLL_USE_ENABLE = use_en_r;
   assign PLL_CORE_RESET = core_rst_r;
   assign PLL_MULTIPLIER = mult_r;
   assign REFERENCE_PRE_DIVIDER = prediv_r;
   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;

   // ==========================================
   // checks
   chk_pll_off_reset: assert property (disable iff (1'b0) $past(RST) |-> !use_en_r)
      else $error("pll path enabled right after reset");
   chk_mult_range: assert property (mult_r >= `MULT_MIN && mult_r <= `MULT_MAX)
      else $error("multiplier out of range");
   chk_mult_refused: assert property (req.sel && req.enable && pready_r &&
      req.write && req.addr == `OFS_MULT && req.wdata[4:0] > `MULT_MAX |=> $stable(mult_r))
      else $error("out of range multiplier was taken");
   chk_defaults_abc: assert property (disable iff (1'b0) $past(RST) |->
      div_shadow_r[0] == 5'h01 && div_shadow_r[1] == 5'h02 && div_shadow_r[2] == 5'h03)
      else $error("divider reset ratios wrong");
   chk_go_ratio_ok: assert property (req.sel && req.enable && pready_r && req.write &&
      req.addr == `OFS_CMD && req.wdata[`CMD_GO_BIT] && !ratio_ok && go_state_r == GO_IDLE
      |=> go_state_r == GO_IDLE && err_r)
      else $error("go accepted with bad second clock ratio");
   chk_go_waits_edge: assert property (fire |-> &(clk_vec | ~align_mask) ##1
      go_state_r == GO_IDLE && clk_vec == 4'h0)
      else $error("dividers loaded off the common boundary");
   chk_go_pending: assert property (go_req && go_state_r == GO_IDLE |=>
      go_state_r == GO_WAIT)
      else $error("go command not taken");
   chk_lock_restart: assert property (lock_restart |=> !lock_done [*2])
      else $error("lock reported too early after a change");
   chk_core_hold: assert property (core_set |=> !reset_ok [*8])
      else $error("core reset hold reported too early");
   chk_ref_merge: assert property (!use_en_r && ref_merged && !ref_prev_r |-> src_tick)
      else $error("reference edge lost");

endmodule : pll_clock_ctrl

`default_nettype wire

// File: test/ref_clk_source.sv
// reference clock source model: on-chip oscillator or external clock pin
`timescale 1ns/1ps
`default_nettype none

module ref_clk_source #(
   parameter int HALF_NS = 40
) (
   input wire logic run,
   input wire logic use_ext,
   output logic osc_out,
   output logic ext_out
);
   logic phase;

   // ==========================================
   // reference generator
   // 80 ns period is 12.5 MHz, inside the band with pre-divider 1
   // offset by 3 ns so no edge lands on the system clock edge
   initial begin
      phase = 1'b0;
      #3;
      forever begin
         #(HALF_NS);
         phase = run ? ~phase : 1'b0;
      end
   end

   // only the chosen source moves, the unused one is held low
   assign osc_out = phase & ~use_ext;
   assign ext_out = phase & use_ext;

endmodule : ref_clk_source
`default_nettype wire

// File: test/tb_top.sv
// self-checking testbench of the pll clock controller
`timescale 1ns/1ps
`default_nettype none
`include "pll_cfg.svh"

module tb_top;
   import pll_pkg::*;
   logic sys_clk, rst, psel, penable, pwrite, ref_run, ref_ext, osc, ext;
   logic pready, pslverr, use_en, core_rst;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic er_v;
   logic [3:0] clks;
   ratio_type mult, prediv;
   int err_total, num_checks;

   // ==========================================
   // clock and design under test
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   ref_clk_source ref_clk_source_inst (.run(ref_run), .use_ext(ref_ext), .osc_out(osc),
      .ext_out(ext));

   // short lock count keeps the run brief
   pll_clock_ctrl #(.LOCK_CYCLES(20)) pll_clock_ctrl_inst (.SYS_CLK(sys_clk), .RST(rst),
      .OSCILLATOR_INPUT(osc), .EXTERNAL_CLOCK_PIN(ext), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SYSTEM_CLOCK_A(clks[0]), .SYSTEM_CLOCK_B(clks[1]),
      .SYSTEM_CLOCK_C(clks[2]), .AUX_CLOCK(clks[3]), .PLL_USE_ENABLE(use_en),
      .PLL_CORE_RESET(core_rst), .PLL_MULTIPLIER(mult), .REFERENCE_PRE_DIVIDER(prediv));

   // ==========================================
   // comparison and closing
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test

   // ==========================================
   // apb master: setup, access, hold until pready sampled high
   task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= is_wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd_v = prdata;
      er_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      check({31'h0, er_v}, {31'h0, e});
   endtask : wr

   task rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      check(rd_v, exp);
      check({31'h0, er_v}, {31'h0, e});
   endtask : rd

   task stat(input int b, input logic exp);
      apb(1'b0, `OFS_STAT, 32'h0);
      check({31'h0, rd_v[b]}, {31'h0, exp});
   endtask : stat

   // period of one output in system cycles, rise to rise
   task automatic per(input int sel, input logic [31:0] exp);
      logic prev;
      int n, k, t0;
      n = 0;
      k = 0;
      t0 = 0;
      prev = 1'b1;
      while (k < 2 && n < 600) begin
         @(posedge sys_clk);
         #1;
         if (clks[sel] === 1'b1 && prev === 1'b0) begin
            if (k == 1) check(32'(n - t0), exp);
            t0 = n;
            k++;
         end
         prev = clks[sel];
         n++;
      end
      if (k < 2) check(32'h0, exp);
   endtask : per

   // ==========================================
   // watchdog: whole run needs well under a thousand cycles
   initial begin
      #300000;
      err_total++;
      end_of_test();
   end

   // ==========================================
   // main sequence
   initial begin
      err_total = 0;
      num_checks = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      ref_run = 1'b0;
      ref_ext = 1'b0;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;

      // reset values: pll path off, core reset held, default ratios
      check({31'h0, use_en}, 32'h0);
      check({31'h0, core_rst}, 32'h1);
      check({27'h0, prediv}, 32'h1);
      rd(`OFS_CTRL, 32'h2, 1'b0);
      rd(`OFS_MULT, 32'hD, 1'b0);
      rd(`OFS_PREDIV, 32'h1, 1'b0);
      rd(`OFS_DIV_A, 32'h1, 1'b0);
      rd(`OFS_DIV_B, 32'h2, 1'b0);
      rd(`OFS_DIV_C, 32'h3, 1'b0);
      rd(`OFS_DIV_AUX, 32'h1, 1'b0);
      rd(`OFS_ALIGN, 32'h0, 1'b0);
      rd(12'h104, 32'h0, 1'b1);
      $display("test reset values done");

      // bypass from the oscillator, then from the pin: ticks every 8 cycles
      ref_run = 1'b1;
      per(0, 32'd16);
      per(1, 32'd32);
      per(2, 32'd48);
      per(3, 32'd16);
      ref_ext = 1'b1;
      repeat (20) @(posedge sys_clk);
      per(0, 32'd16);
      ref_run = 1'b0;
      $display("test reference merge done");

      // multiplier bounds and zero dividers refused
      wr(`OFS_MULT, 32'h3, 1'b1);
      wr(`OFS_MULT, 32'h1A, 1'b1);
      rd(`OFS_MULT, 32'hD, 1'b0);
      wr(`OFS_MULT, 32'h4, 1'b0);
      wr(`OFS_MULT, 32'h19, 1'b0);
      // the register updates at the completing edge, so look once it has settled
      #1;
      check({27'h0, mult}, 32'h19);
      wr(`OFS_PREDIV, 32'h0, 1'b1);
      wr(`OFS_DIV_A, 32'h0, 1'b1);
      $display("test ranges done");

      // core reset hold and lock timing status
      wr(`OFS_CTRL, 32'h0, 1'b0);
      stat(1, 1'b0);
      repeat (25) @(posedge sys_clk);
      stat(1, 1'b1);
      // x20 on the 12.5 MHz reference keeps the pll output at 250 MHz
      wr(`OFS_MULT, 32'h14, 1'b0);
      stat(1, 1'b0);
      wr(`OFS_CTRL, 32'h2, 1'b0);
      stat(2, 1'b0);
      repeat (15) @(posedge sys_clk);
      stat(2, 1'b1);
      wr(`OFS_CTRL, 32'h0, 1'b0);
      repeat (25) @(posedge sys_clk);
      wr(`OFS_CTRL, 32'h1, 1'b0);
      #1;
      check({31'h0, use_en}, 32'h1);
      $display("test lock timing done");

      // pll path: one tick per cycle, new ratios wait for go
      per(0, 32'd2);
      per(1, 32'd4);
      per(2, 32'd6);
      wr(`OFS_DIV_A, 32'h2, 1'b0);
      wr(`OFS_DIV_B, 32'h6, 1'b0);
      wr(`OFS_DIV_C, 32'h4, 1'b0);
      wr(`OFS_DIV_AUX, 32'h3, 1'b0);
      per(0, 32'd2);
      per(1, 32'd4);
      wr(`OFS_ALIGN, 32'h7, 1'b0);
      rd(`OFS_ALIGN, 32'h7, 1'b0);
      // bridge reset after a ratio change is left to software outside this block
      wr(`OFS_CMD, 32'h1, 1'b0);
      for (int i = 0; i < 20; i++) begin
         apb(1'b0, `OFS_STAT, 32'h0);
         if (rd_v[0] === 1'b0) break;
      end
      check({31'h0, rd_v[0]}, 32'h0);
      check({31'h0, rd_v[3]}, 32'h0);
      per(0, 32'd4);
      per(1, 32'd12);
      per(2, 32'd8);
      per(3, 32'd6);
      rd(`OFS_CMD, 32'h0, 1'b0);
      $display("test aligned go done");

      // second clock ratio 2.5 of the first: go refused, ratios kept
      wr(`OFS_DIV_B, 32'h5, 1'b0);
      wr(`OFS_CMD, 32'h1, 1'b1);
      stat(3, 1'b1);
      per(1, 32'd12);
      $display("test refused go done");
      end_of_test();
   end

endmodule : tb_top
`default_nettype wire
